// [rtl/mpf_deadtime_protect.sv]
// Function
// - Dead-time on delays each PWM input rising edge, before output inversion, by the 8-bit dead-time count.
// - Dead-time tick is clock divided by 4, or by 8 when prescale select set.
// - Protection control holds enables for pin, four comparators, three ADC compares.
// - Protection enabled at reset; guard-off set only after key A5A5.
// - Bits 13..8 give forced levels for UH, UL, VH, VL, WH, WL.
// - Protection is left through release bit, accepted only after key 39AA.
// - Protection filter length zero is unfiltered, otherwise stable-time filter.
// - Protection scope: none, low sides, high sides, or all six forced.
// - Key field in protection status upper half unlocks guarded control bits.
// - Protection status shows active at bit 7, filtered input at bit 0.
// - Over-voltage control holds enables for pin, comparators, ADC compares.
// - Over-voltage disabled at reset; arm set only after key 7788.
// - Over-voltage released through release bit only after key 5596.
// - Over-voltage filter length zero is unfiltered, otherwise stable-time filter.
// - Over-voltage scope: none, high up low down, reverse, or programmed levels.
// - Over-voltage status shows active at bit 7, input at bit 0.
`timescale 1ns/1ps
module mpf_deadtime_protect (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Register port
  input  wire mpf_pkg::mpf_bus_req_t   bus_req,
  output logic [31:0]                  bus_rdata,
  // PWM path
  input  wire logic [5:0]              pwm_in,
  input  wire logic [5:0]              output_inversion,
  output logic [5:0]                   pwm_out,
  // Fault sources
  input  wire mpf_pkg::mpf_fault_in_t  fault_in,
  // Interrupt
  output logic                         irq
);

  // Register decode.
  wire sel_dt   = bus_req.addr == mpf_pkg::DT_CFG_ADDR;
  wire sel_fpc  = bus_req.addr == mpf_pkg::FP_CTRL_ADDR;
  wire sel_fps  = bus_req.addr == mpf_pkg::FP_STAT_ADDR;
  wire sel_ovc  = bus_req.addr == mpf_pkg::OV_CTRL_ADDR;
  wire sel_ovs  = bus_req.addr == mpf_pkg::OV_STAT_ADDR;
  wire sel_ist  = bus_req.addr == mpf_pkg::IRQ_STAT_ADDR;
  wire sel_imsk = bus_req.addr == mpf_pkg::IRQ_MASK_ADDR;
  wire wr_dt    = bus_req.wr && sel_dt;
  wire wr_fpc   = bus_req.wr && sel_fpc;
  wire wr_fps   = bus_req.wr && sel_fps;
  wire wr_ovc   = bus_req.wr && sel_ovc;
  wire wr_ist   = bus_req.wr && sel_ist;
  wire wr_imsk  = bus_req.wr && sel_imsk;
  wire [31:0] wd = bus_req.wdata;

  logic [15:0] dt_cfg_r;
  logic [7:0]  fp_src_r;
  logic        fault_guard_off_r;
  logic [5:0]  fault_level_r;
  logic [2:0]  fault_filter_len_r;
  logic [1:0]  fault_output_scope_r;
  logic [7:0]  ov_src_r;
  logic        overvolt_arm_r;
  logic [2:0]  overvolt_filter_len_r;
  logic [1:0]  overvolt_output_scope_r;
  logic [15:0] unlock_key_r;
  logic        fault_active_flag_r;
  logic        overvolt_active_flag_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [31:0] rdata_r;
  logic [5:0]  pwm_out_r;

  // Key decode: each key arms only its own operation.
  // key arms operation
  wire key_guard  = unlock_key_r == mpf_pkg::KEY_GUARD_OFF;
  wire key_fp_rel = unlock_key_r == mpf_pkg::KEY_FP_RELEASE;
  wire key_ov_arm = unlock_key_r == mpf_pkg::KEY_OV_ARM;
  wire key_ov_rel = unlock_key_r == mpf_pkg::KEY_OV_RELEASE;

  wire guard_off_nxt = !wr_fpc ? fault_guard_off_r :
                       !wd[mpf_pkg::GUARD_BIT] ? 1'b0 :
                       (key_guard ? 1'b1 : fault_guard_off_r);
  wire ov_arm_nxt = !wr_ovc ? overvolt_arm_r :
                    !wd[mpf_pkg::GUARD_BIT] ? 1'b0 :
                    (key_ov_arm ? 1'b1 : overvolt_arm_r);
  wire fp_release = wr_fpc && wd[mpf_pkg::RELEASE_BIT] && key_fp_rel;
  wire ov_release = wr_ovc && wd[mpf_pkg::RELEASE_BIT] && key_ov_rel;

  // The key is consumed by the next control write, whatever it held.
  wire [15:0] key_nxt = wr_fps ? wd[31:16] :
                        (wr_fpc || wr_ovc) ? mpf_pkg::KEY_RST : unlock_key_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dt_cfg_r                <= mpf_pkg::DT_CFG_RST;
      fp_src_r                <= mpf_pkg::SRC_RST;
      fault_guard_off_r       <= 1'b0;
      fault_level_r           <= mpf_pkg::LVL_RST;
      fault_filter_len_r      <= mpf_pkg::FILT_RST;
      fault_output_scope_r    <= mpf_pkg::SCOPE_RST;
      ov_src_r                <= mpf_pkg::SRC_RST;
      overvolt_arm_r          <= 1'b0;
      overvolt_filter_len_r   <= mpf_pkg::FILT_RST;
      overvolt_output_scope_r <= mpf_pkg::SCOPE_RST;
      unlock_key_r            <= mpf_pkg::KEY_RST;
      irq_mask_r              <= mpf_pkg::IRQ_RST;
    end else begin
      unlock_key_r      <= key_nxt;
      fault_guard_off_r <= guard_off_nxt;
      overvolt_arm_r    <= ov_arm_nxt;
      if (wr_dt) begin
        dt_cfg_r <= {wd[15], 6'h00, wd[8], wd[7:0]};
      end
      if (wr_fpc) begin
        fp_src_r             <= wd[mpf_pkg::SRC_LSB +: 8];
        fault_level_r        <= wd[mpf_pkg::LVL_LSB +: 6];
        fault_filter_len_r   <= wd[mpf_pkg::FILT_LSB +: 3];
        fault_output_scope_r <= wd[mpf_pkg::SCOPE_LSB +: 2];
      end
      if (wr_ovc) begin
        ov_src_r                <= wd[mpf_pkg::SRC_LSB +: 8];
        overvolt_filter_len_r   <= wd[mpf_pkg::FILT_LSB +: 3];
        overvolt_output_scope_r <= wd[mpf_pkg::SCOPE_LSB +: 2];
      end
      if (wr_imsk) begin
        irq_mask_r <= wd[1:0];
      end
    end
  end

  // Fault source gathering, bit 7 pin, 6..3 comparators, 2..0 ADC compares.
  wire [6:0] shared_src = {fault_in.cmp, fault_in.adc_cmp};
  wire [1:0] raw_fault;
  assign raw_fault[0] = |(fp_src_r & {fault_in.fault_pin, shared_src});
  assign raw_fault[1] = |(ov_src_r & {fault_in.overvolt_pin, shared_src});
  wire [2:0] filt_len [2];
  assign filt_len[0] = fault_filter_len_r;
  assign filt_len[1] = overvolt_filter_len_r;

  // Debounce: the filtered level follows the raw level only after it has
  // differed for the programmed number of clocks; zero passes it straight.
  logic [1:0] filt_q;
  genvar gf;
  generate
    for (gf = 0; gf < 2; gf++) begin : g_filt
      logic [2:0] cnt_r;
      wire        differ  = raw_fault[gf] != filt_q[gf];
      wire [2:0]  cnt_inc = cnt_r + 3'h1;
      wire        pass    = (filt_len[gf] == 3'h0) || (differ && cnt_inc >= filt_len[gf]);
      wire        filt_nxt = pass ? raw_fault[gf] : filt_q[gf];
      wire [2:0]  cnt_nxt  = (pass || !differ) ? 3'h0 : cnt_inc;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r      <= 3'h0;
          filt_q[gf] <= 1'b0;
        end else begin
          cnt_r      <= cnt_nxt;
          filt_q[gf] <= filt_nxt;
        end
      end
    end
  endgenerate

  // latch until keyed release; set wins
  wire fp_set      = filt_q[0] && !fault_guard_off_r;
  wire ov_set      = filt_q[1] && overvolt_arm_r;
  wire fp_act_nxt  = fp_set || (fault_active_flag_r && !fp_release);
  wire ov_act_nxt  = ov_set || (overvolt_active_flag_r && !ov_release);
  wire [1:0] irq_ev = {ov_set && !overvolt_active_flag_r, fp_set && !fault_active_flag_r};
  wire [1:0] irq_clr = wr_ist ? wd[1:0] : 2'h0;
  wire [1:0] irq_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_active_flag_r    <= 1'b0;
      overvolt_active_flag_r <= 1'b0;
      irq_stat_r             <= mpf_pkg::IRQ_RST;
    end else begin
      fault_active_flag_r    <= fp_act_nxt;
      overvolt_active_flag_r <= ov_act_nxt;
      irq_stat_r             <= irq_nxt;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Dead-time prescaler.
  logic [2:0] div_r;
  wire [2:0] div_last = dt_cfg_r[mpf_pkg::DT_PRESC_BIT] ? mpf_pkg::DIV8_LAST : mpf_pkg::DIV4_LAST;
  wire       dt_tick  = div_r >= div_last;
  wire [2:0] div_nxt  = dt_tick ? 3'h0 : div_r + 3'h1;
  wire       dt_on    = dt_cfg_r[mpf_pkg::DT_ON_BIT];
  wire [7:0] dt_count = dt_cfg_r[mpf_pkg::DT_CNT_LSB +: 8];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Per-output dead-time delay of the rising edge, before polarity.
  logic [5:0] dt_q;
  logic [5:0] pwm_prev_r;
  genvar gd;
  generate
    for (gd = 0; gd < 6; gd++) begin : g_dt
      logic [7:0] wait_r;
      wire        rise     = pwm_in[gd] && !pwm_prev_r[gd];
      wire [7:0]  wait_dec = (dt_tick && wait_r != 8'h00) ? wait_r - 8'h01 : wait_r;
      wire [7:0]  wait_nxt = !pwm_in[gd] ? 8'h00 : ((rise && dt_on) ? dt_count : wait_dec);
      wire        dt_nxt   = pwm_in[gd] && (wait_nxt == 8'h00);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wait_r         <= 8'h00;
          dt_q[gd]       <= 1'b0;
          pwm_prev_r[gd] <= 1'b0;
        end else begin
          wait_r         <= wait_nxt;
          dt_q[gd]       <= dt_nxt;
          pwm_prev_r[gd] <= pwm_in[gd];
        end
      end
    end
  endgenerate

  // Output forcing; protection outranks over-voltage on the bits it owns.
  wire [5:0] norm_out = dt_q ^ output_inversion;
  wire [5:0] fp_mask  = (fault_output_scope_r[1] ? mpf_pkg::HIGH_SIDES : 6'h00) |
                        (fault_output_scope_r[0] ? mpf_pkg::LOW_SIDES : 6'h00);
  wire [5:0] ov_mask  = (overvolt_output_scope_r != 2'h0) ? 6'h3F : 6'h00;
  wire [5:0] ov_val   = (overvolt_output_scope_r == 2'h1) ? (mpf_pkg::HIGH_SIDES ^ output_inversion) :
                        (overvolt_output_scope_r == 2'h2) ? (mpf_pkg::LOW_SIDES ^ output_inversion) :
                        fault_level_r;
  wire [5:0] ov_stage = overvolt_active_flag_r ? ((ov_mask & ov_val) | (~ov_mask & norm_out)) : norm_out;
  wire [5:0] out_nxt  = fault_active_flag_r ? ((fp_mask & fault_level_r) | (~fp_mask & ov_stage)) : ov_stage;

  // Read mux.
  // control and status readback
  wire [31:0] fpc_rd = {8'h00, fp_src_r, fault_guard_off_r, 1'b0, fault_level_r, 1'b0,
                        fault_filter_len_r, 2'h0, fault_output_scope_r};
  wire [31:0] ovc_rd = {8'h00, ov_src_r, overvolt_arm_r, 7'h00, 1'b0,
                        overvolt_filter_len_r, 2'h0, overvolt_output_scope_r};
  wire [31:0] fps_rd = {unlock_key_r, 8'h00, fault_active_flag_r, 6'h00, filt_q[0]};
  wire [31:0] ovs_rd = {24'h000000, overvolt_active_flag_r, 6'h00, filt_q[1]};
  wire [31:0] rd_mux = sel_dt   ? {16'h0000, dt_cfg_r} :
                       sel_fpc  ? fpc_rd :
                       sel_fps  ? fps_rd :
                       sel_ovc  ? ovc_rd :
                       sel_ovs  ? ovs_rd :
                       sel_ist  ? {30'h00000000, irq_stat_r} :
                       sel_imsk ? {30'h00000000, irq_mask_r} : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r   <= 32'h00000000;
      pwm_out_r <= 6'h00;
    end else begin
      rdata_r   <= bus_req.rd ? rd_mux : 32'h00000000;
      pwm_out_r <= out_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign pwm_out   = pwm_out_r;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_keyless_guard_write;
    wr_fpc && wd[mpf_pkg::GUARD_BIT] && !key_guard;
  endsequence

  sequence s_key_then_release;
    wr_fps && wd[31:16] == mpf_pkg::KEY_FP_RELEASE ##1 wr_fpc && wd[mpf_pkg::RELEASE_BIT];
  endsequence

  property p_guard_needs_key;
    s_keyless_guard_write and !fault_guard_off_r |=> !fault_guard_off_r;
  endproperty
  a_guard_needs_key: assert property (p_guard_needs_key) else $error("guard-off set without key");

  property p_ov_arm_needs_key;
    wr_ovc && wd[mpf_pkg::GUARD_BIT] && !key_ov_arm && !overvolt_arm_r |=> !overvolt_arm_r;
  endproperty
  a_ov_arm_needs_key: assert property (p_ov_arm_needs_key) else $error("ov arm set without key");

  property p_fp_holds;
    fault_active_flag_r && !fp_release |=> fault_active_flag_r;
  endproperty
  a_fp_holds: assert property (p_fp_holds) else $error("protection dropped without release");

  // The fault must be quiet in the release cycle, since a new set wins.
  property p_keyed_release;
    s_key_then_release and (##1 !fp_set) |=> !fault_active_flag_r;
  endproperty
  a_keyed_release: assert property (p_keyed_release) else $error("keyed release not taken");

  property p_fp_all_levels;
    fault_active_flag_r && fault_output_scope_r == 2'h3 |=> pwm_out == $past(fault_level_r);
  endproperty
  a_fp_all_levels: assert property (p_fp_all_levels) else $error("forced levels not driven");

  property p_fp_status_read;
    bus_req.rd && sel_fps |=> bus_rdata[mpf_pkg::ACTIVE_BIT] == $past(fault_active_flag_r);
  endproperty
  a_fp_status_read: assert property (p_fp_status_read) else $error("protection status wrong");

  property p_ov_high_low;
    overvolt_active_flag_r && !fault_active_flag_r && overvolt_output_scope_r == 2'h1
      |=> pwm_out == $past(mpf_pkg::HIGH_SIDES ^ output_inversion);
  endproperty
  a_ov_high_low: assert property (p_ov_high_low) else $error("ov scope 01 output wrong");

  property p_dt_delays_rise;
    $rose(pwm_in[0]) && dt_on && dt_count > 8'h01 |=> !dt_q[0] [*5];
  endproperty
  a_dt_delays_rise: assert property (p_dt_delays_rise) else $error("dead time not applied");

  property p_tick_spacing;
    dt_tick |=> !dt_tick [*3];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("prescale tick too early");

  property p_no_filter;
    fault_filter_len_r == 3'h0 |=> filt_q[0] == $past(raw_fault[0]);
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("unfiltered path delayed");

  property p_ov_status_read;
    bus_req.rd && sel_ovs |=> bus_rdata[mpf_pkg::INSTATE_BIT] == $past(filt_q[1]);
  endproperty
  a_ov_status_read: assert property (p_ov_status_read) else $error("ov status wrong");

  property p_ov_no_filter;
    overvolt_filter_len_r == 3'h0 |=> filt_q[1] == $past(raw_fault[1]);
  endproperty
  a_ov_no_filter: assert property (p_ov_no_filter) else $error("ov unfiltered path delayed");

  sequence s_ov_key_then_release;
    wr_fps && wd[31:16] == mpf_pkg::KEY_OV_RELEASE ##1 wr_ovc && wd[mpf_pkg::RELEASE_BIT];
  endsequence

  property p_ov_keyed_release;
    s_ov_key_then_release and (##1 !ov_set) |=> !overvolt_active_flag_r;
  endproperty
  a_ov_keyed_release: assert property (p_ov_keyed_release) else $error("ov keyed release not taken");

  property p_fp_low_scope;
    fault_active_flag_r && fault_output_scope_r == 2'h1
      |=> (pwm_out & mpf_pkg::LOW_SIDES) == $past(fault_level_r & mpf_pkg::LOW_SIDES);
  endproperty
  a_fp_low_scope: assert property (p_fp_low_scope) else $error("low side levels not forced");

  property p_fp_high_scope;
    fault_active_flag_r && fault_output_scope_r == 2'h2
      |=> (pwm_out & mpf_pkg::HIGH_SIDES) == $past(fault_level_r & mpf_pkg::HIGH_SIDES);
  endproperty
  a_fp_high_scope: assert property (p_fp_high_scope) else $error("high side levels not forced");

  property p_ov_low_high;
    overvolt_active_flag_r && !fault_active_flag_r && overvolt_output_scope_r == 2'h2
      |=> pwm_out == $past(mpf_pkg::LOW_SIDES ^ output_inversion);
  endproperty
  a_ov_low_high: assert property (p_ov_low_high) else $error("ov scope 10 output wrong");

  property p_dt_fall;
    !pwm_in[0] |=> !dt_q[0];
  endproperty
  a_dt_fall: assert property (p_dt_fall) else $error("falling edge delayed");

  // A latch event in the same cycle as a clear must leave its status bit set.
  property p_irq_set_wins;
    irq_ev != 2'h0 |=> (irq_stat_r & $past(irq_ev)) == $past(irq_ev);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("event status bit lost");

endmodule : mpf_deadtime_protect

// [rtl/mpf_pkg.sv]
package mpf_pkg;

  // Register byte addresses.
  localparam logic [31:0] DT_CFG_ADDR  = 32'h4000403C;
  localparam logic [31:0] FP_CTRL_ADDR = 32'h40004040;
  localparam logic [31:0] FP_STAT_ADDR = 32'h40004044;
  localparam logic [31:0] OV_CTRL_ADDR = 32'h40004048;
  localparam logic [31:0] OV_STAT_ADDR = 32'h4000404C;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'h40004070;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h40004074;

  // Dead-time register fields.
  localparam int DT_ON_BIT    = 15;
  localparam int DT_PRESC_BIT = 8;
  localparam int DT_CNT_LSB   = 0;

  // Shared control and status register fields.
  localparam int SRC_LSB      = 16;
  localparam int GUARD_BIT    = 15;
  localparam int LVL_LSB      = 8;
  localparam int RELEASE_BIT  = 7;
  localparam int FILT_LSB     = 4;
  localparam int SCOPE_LSB    = 0;
  localparam int KEY_LSB      = 16;
  localparam int ACTIVE_BIT   = 7;
  localparam int INSTATE_BIT  = 0;

  // Unlock keys.
  localparam logic [15:0] KEY_GUARD_OFF  = 16'hA5A5;
  localparam logic [15:0] KEY_FP_RELEASE = 16'h39AA;
  localparam logic [15:0] KEY_OV_ARM     = 16'h7788;
  localparam logic [15:0] KEY_OV_RELEASE = 16'h5596;

  // Dead-time prescaler terminal counts.
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // Output index map: 5 UH, 4 UL, 3 VH, 2 VL, 1 WH, 0 WL.
  localparam logic [5:0] HIGH_SIDES = 6'h2A;
  localparam logic [5:0] LOW_SIDES  = 6'h15;

  // Reset values.
  localparam logic [15:0] DT_CFG_RST = 16'h0000;
  localparam logic [7:0]  SRC_RST    = 8'h00;
  localparam logic [5:0]  LVL_RST    = 6'h00;
  localparam logic [2:0]  FILT_RST   = 3'h0;
  localparam logic [1:0]  SCOPE_RST  = 2'h0;
  localparam logic [15:0] KEY_RST    = 16'h0000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;

  // Interrupt status bits.
  localparam int IRQ_FP_BIT = 0;
  localparam int IRQ_OV_BIT = 1;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mpf_bus_req_t;

  typedef struct packed {
    logic       fault_pin;
    logic       overvolt_pin;
    logic [3:0] cmp;
    logic [2:0] adc_cmp;
  } mpf_fault_in_t;

endpackage : mpf_pkg

// [verif/mpf_bridge_model.sv]
`timescale 1ns/1ps
module mpf_bridge_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Requested levels: pin, ov pin, cmp 3..0, adc 2..0
  input  wire logic [8:0]        trip,
  // Fault lines toward the block
  output mpf_pkg::mpf_fault_in_t fault_in
);
  // Comparator outputs settle one clock after the analog event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_in <= '0;
    end else begin
      fault_in <= mpf_pkg::mpf_fault_in_t'(trip);
    end
  end
endmodule : mpf_bridge_model

// [verif/test_motor_pwm_deadtime_fault_protect.sv]
`timescale 1ns/1ps
module test_motor_pwm_deadtime_fault_protect;
  logic                   clk;
  logic                   rst_n;
  mpf_pkg::mpf_bus_req_t  req;
  logic [31:0]            rdata;
  logic [5:0]             pwm_in;
  logic [5:0]             inv;
  logic [5:0]             pwm_out;
  logic [8:0]             trip;
  mpf_pkg::mpf_fault_in_t fault_in;
  logic                   irq;
  int                     fails;
  int                     n_checks;
  logic [31:0]            rv;

  mpf_deadtime_protect mpf_deadtime_protect_inst (.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
    .pwm_in(pwm_in), .output_inversion(inv), .pwm_out(pwm_out), .fault_in(fault_in), .irq(irq));
  mpf_bridge_model mpf_bridge_model_inst (.clk(clk), .rst_n(rst_n), .trip(trip), .fault_in(fault_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic wr_keyed(input logic [15:0] k, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: mpf_pkg::FP_STAT_ADDR, wdata: {k, 16'h0000}, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr_keyed

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wait_flag(input logic [31:0] a, input logic v);
    for (int i = 0; i < 40; i++) begin
      rd(a);
      if (rv[7] === v) break;
    end
  endtask : wait_flag

  task automatic t_reset();
    logic [31:0] adr [6];
    adr = '{mpf_pkg::DT_CFG_ADDR, mpf_pkg::FP_CTRL_ADDR, mpf_pkg::FP_STAT_ADDR, mpf_pkg::OV_CTRL_ADDR,
      mpf_pkg::OV_STAT_ADDR, 32'h40004050};
    wr(mpf_pkg::OV_STAT_ADDR, 32'hFFFFFFFF);
    wr(32'h40004050, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      rd(adr[i]);
      chk("reset value", 32'h0, rv);
    end
    @(posedge clk) pwm_in <= 6'h2A;
    cyc(2);
    chk("pass through", 32'h2A, pwm_out);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_protect();
    logic [5:0] m [4];
    m = '{6'h00, mpf_pkg::LOW_SIDES, mpf_pkg::HIGH_SIDES, 6'h3F};
    wr(mpf_pkg::FP_CTRL_ADDR, 32'h00801503);
    @(posedge clk) trip <= 9'h100;
    wait_flag(mpf_pkg::FP_STAT_ADDR, 1'b1);
    chk("fault status", 32'h81, rv);
    chk("irq masked", 32'h0, irq);
    rd(mpf_pkg::IRQ_STAT_ADDR);
    chk("irq status", 32'h1, rv);
    wr(mpf_pkg::IRQ_MASK_ADDR, 32'h1);
    #1 chk("irq raised", 32'h1, irq);
    for (int i = 0; i < 4; i++) begin
      wr(mpf_pkg::FP_CTRL_ADDR, 32'h00801500 | i);
      cyc(2);
      chk("fault scope", (6'h2A & ~m[i]) | (6'h15 & m[i]), pwm_out);
    end
    @(posedge clk) trip <= 9'h0;
    wr(mpf_pkg::FP_CTRL_ADDR, 32'h00801583);
    wr_keyed(mpf_pkg::KEY_GUARD_OFF, mpf_pkg::FP_CTRL_ADDR, 32'h00801583);
    cyc(3);
    rd(mpf_pkg::FP_STAT_ADDR);
    chk("latched without key", 32'h80, rv);
    wr_keyed(mpf_pkg::KEY_FP_RELEASE, mpf_pkg::FP_CTRL_ADDR, 32'h00801583);
    wait_flag(mpf_pkg::FP_STAT_ADDR, 1'b0);
    chk("released", 32'h0, rv);
    cyc(2);
    chk("outputs back", 32'h2A, pwm_out);
    wr(mpf_pkg::IRQ_STAT_ADDR, 32'h1);
    #1 chk("irq cleared", 32'h0, irq);
    $display("t_protect done");
  endtask : t_protect

  task automatic t_guard();
    wr(mpf_pkg::FP_CTRL_ADDR, 32'h00808000);
    rd(mpf_pkg::FP_CTRL_ADDR);
    chk("guard no key", 32'h00800000, rv);
    wr_keyed(mpf_pkg::KEY_GUARD_OFF, mpf_pkg::FP_CTRL_ADDR, 32'h00808000);
    rd(mpf_pkg::FP_CTRL_ADDR);
    chk("guard keyed", 32'h00808000, rv);
    @(posedge clk) trip <= 9'h100;
    cyc(10);
    rd(mpf_pkg::FP_STAT_ADDR);
    chk("guarded status", 32'h01, rv);
    chk("guarded irq", 32'h0, irq);
    @(posedge clk) trip <= 9'h0;
    wr(mpf_pkg::FP_CTRL_ADDR, 32'h00003F00);
    $display("t_guard done");
  endtask : t_guard

  task automatic t_ov();
    logic [5:0] e [4];
    e = '{6'h3C, mpf_pkg::HIGH_SIDES ^ 6'h0F, mpf_pkg::LOW_SIDES ^ 6'h0F, 6'h3F};
    // Inputs unlike either forced pattern, so every scope is told apart.
    @(posedge clk);
    inv    <= 6'h0F;
    pwm_in <= 6'h33;
    wr(mpf_pkg::OV_CTRL_ADDR, 32'h00088000);
    rd(mpf_pkg::OV_CTRL_ADDR);
    chk("arm no key", 32'h00080000, rv);
    wr_keyed(mpf_pkg::KEY_OV_ARM, mpf_pkg::OV_CTRL_ADDR, 32'h00088000);
    @(posedge clk) trip <= 9'h008;
    wait_flag(mpf_pkg::OV_STAT_ADDR, 1'b1);
    chk("ov status", 32'h81, rv);
    for (int i = 0; i < 4; i++) begin
      wr(mpf_pkg::OV_CTRL_ADDR, 32'h00088000 | i);
      cyc(2);
      chk("ov scope", e[i], pwm_out);
    end
    @(posedge clk) trip <= 9'h0;
    wr_keyed(mpf_pkg::KEY_OV_RELEASE, mpf_pkg::OV_CTRL_ADDR, 32'h00088083);
    wait_flag(mpf_pkg::OV_STAT_ADDR, 1'b0);
    chk("ov released", 32'h0, rv);
    wr(mpf_pkg::OV_CTRL_ADDR, 32'h0);
    @(posedge clk) inv <= 6'h00;
    $display("t_ov done");
  endtask : t_ov

  task automatic t_filter();
    wr(mpf_pkg::FP_CTRL_ADDR, 32'h00100070);
    @(posedge clk) trip <= 9'h010;
    repeat (5) @(posedge clk);
    trip <= 9'h0;
    cyc(12);
    rd(mpf_pkg::FP_STAT_ADDR);
    chk("glitch filtered", 32'h0, rv);
    @(posedge clk) trip <= 9'h010;
    cyc(20);
    rd(mpf_pkg::FP_STAT_ADDR);
    chk("steady fault", 32'h81, rv);
    @(posedge clk) trip <= 9'h0;
    // The filtered level must fall first, or the still-set fault wins over the release.
    cyc(10);
    wr_keyed(mpf_pkg::KEY_FP_RELEASE, mpf_pkg::FP_CTRL_ADDR, 32'h001000F0);
    wait_flag(mpf_pkg::FP_STAT_ADDR, 1'b0);
    chk("filter released", 32'h0, rv);
    wr(mpf_pkg::FP_CTRL_ADDR, 32'h0);
    $display("t_filter done");
  endtask : t_filter

  task automatic t_dead(input logic [15:0] cfg, input int p);
    int n;
    int c;
    c = int'(cfg[7:0]);
    wr(mpf_pkg::DT_CFG_ADDR, {16'h0, cfg});
    @(posedge clk) pwm_in <= 6'h00;
    cyc(4);
    @(posedge clk) pwm_in <= 6'h01;
    n = 0;
    while (pwm_out[0] !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("dead time span", 32'h1, 32'((n >= (c - 1) * p + 1) && (n <= c * p + 3)));
    @(posedge clk) pwm_in <= 6'h00;
    cyc(2);
    chk("fall direct", 32'h0, pwm_out);
    $display("t_dead done");
  endtask : t_dead

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    req = '0;
    pwm_in = '0;
    inv = '0;
    trip = '0;
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_protect();
    t_guard();
    t_ov();
    t_filter();
    t_dead(16'h8004, 4);
    t_dead(16'h8104, 8);
    t_dead(16'h81FF, 8);
    tally_and_finish();
  end
endmodule : test_motor_pwm_deadtime_fault_protect
